// File: src/pmcc_params.svh
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH

// --------------------
// Command codes
// --------------------
`define PMCC_CMD_P      8'h42
`define PMCC_CMD_Q      8'h32
`define PMCC_CMD_S      8'h3A
`define PMCC_CMD_AVG    8'h5A
`define PMCC_CMD_VOLT   8'h4A
`define PMCC_CMD_CURR   8'h52
`define PMCC_CMD_IGAIN  8'h2B
`define PMCC_CMD_VGAIN  8'h2A
`define PMCC_CMD_CFG    8'h22
`define PMCC_CMD_POFFS  8'h84
`define PMCC_CMD_PGAIN  8'h8C
`define PMCC_CMD_RCP    8'hB2
`define PMCC_CMD_CVG    8'hBA
`define PMCC_CMD_IOFFS  8'hAC
`define PMCC_CMD_IOV    8'hAD

// --------------------
// Configuration word fields
// --------------------
`define PMCC_CFG_NOCUR  0
`define PMCC_CFG_PEC    3
`define PMCC_CFG_RUN    4
`define PMCC_CFG_DONE   5
`define PMCC_CFG_RESET  16'hF122

// --------------------
// Arithmetic
// --------------------
`define PMCC_CRC_POLY   8'h07
`define PMCC_DIV_STEPS  6'h30
`define PMCC_SQRT_STEPS 5'h18

`endif

// File: src/pmcc_pkg.sv
package pmcc_pkg;

    typedef enum logic [1:0]
    {
        st_idle,
        st_div,
        st_app,
        st_sqrt
    } pmcc_state_t;

endpackage

// File: src/pmcc_div.sv
`timescale 1ns/1ps
`include "pmcc_params.svh"

module pmcc_div
    import pmcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [47:0] dividend,
    input wire logic [23:0] divisor,
    // Answer
    output logic done,
    output logic [47:0] quotient
);

    logic [24:0] rem_q;
    logic [47:0] quo_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire [24:0] trial = {rem_q[23:0], quo_q[47]};
    wire fits = trial >= {1'b0, divisor};

    // --------------------
    // Restoring division, one bit per cycle
    // --------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rem_q <= 25'h000_0000;
            quo_q <= 48'h0000_0000_0000;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start)
        begin
            rem_q <= 25'h000_0000;
            quo_q <= dividend;
            cnt_q <= `PMCC_DIV_STEPS;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= busy_q && cnt_q == 6'h01;
            if (busy_q)
            begin
                rem_q <= fits ? trial - {1'b0, divisor} : trial;
                quo_q <= {quo_q[46:0], fits};
                cnt_q <= cnt_q - 6'h01;
                busy_q <= cnt_q != 6'h01;
            end
        end
    end

    assign done = done_q;
    assign quotient = quo_q;

endmodule // pmcc_div

// File: src/pmcc_sqrt.sv
`timescale 1ns/1ps
`include "pmcc_params.svh"

module pmcc_sqrt
    import pmcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [47:0] radicand,
    // Answer
    output logic done,
    output logic [23:0] root
);

    logic [25:0] rem_q;
    logic [23:0] root_q;
    logic [47:0] rad_q;
    logic [4:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire [25:0] trial = {rem_q[23:0], rad_q[47:46]};
    wire [25:0] test = {root_q, 2'b01};
    wire fits = trial >= test;

    // --------------------
    // Digit-by-digit root, two radicand bits per cycle
    // --------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rem_q <= 26'h000_0000;
            root_q <= 24'h00_0000;
            rad_q <= 48'h0000_0000_0000;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start)
        begin
            rem_q <= 26'h000_0000;
            root_q <= 24'h00_0000;
            rad_q <= radicand;
            cnt_q <= `PMCC_SQRT_STEPS;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= busy_q && cnt_q == 5'h01;
            if (busy_q)
            begin
                rem_q <= fits ? trial - test : trial;
                root_q <= {root_q[22:0], fits};
                rad_q <= {rad_q[45:0], 2'b00};
                cnt_q <= cnt_q - 5'h01;
                busy_q <= cnt_q != 5'h01;
            end
        end
    end

    assign done = done_q;
    assign root = root_q;

endmodule // pmcc_sqrt

// File: src/pmcc_top.sv
// Summary of operation
// - Config bit 0 high stops current measurements; low (reset) measures.
// - Config bit 3 high enables a packet-error byte; low (reset) none.
// - Error byte is CRC-8, polynomial x8+x2+x+1, starting from zero.
// - Config bit 4 high accumulates average power; low stops, reset low.
// - Bit 5 reads 0 while average computes after stop, 1 when done.
// - Setting the accumulate bit again clears the done flag.
// - Config bit 6 selects pulse-width aux output; low selects serial.
// - Config bit 7 high disables gain switching; low (reset) enables.
// - Config bit 8 selects current amp gain: 1 is x4 (reset), 0 x1.
// - Config bit 9 selects AC mode when 1, DC (reset) when 0.
// - Every reset sets the indicator field, bits 12-15, to all ones.
// - Indicator reads and writes have no side effect.
// - RMS results use 2^24 as full reference voltage.
// - Power results scale by ratios and reference squared over 1000*2^24.
// - Corrected current adds offsets, gained raw value and reciprocal term.
// - Gain coefficients scale by 1 + c/2^16; all reset to zero.
// - Active power is raw plus offset, times voltage, current, power gains.
// - Apparent power is corrected voltage times corrected current.
// - Reactive power is root of apparent squared minus active squared.
`timescale 1ns/1ps
`include "pmcc_params.svh"

module pmcc_top
    import pmcc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port from the serial slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [23:0] reg_rdata,
    // Packet-error code
    input wire logic pec_clear,
    input wire logic pec_byte_valid,
    input wire logic [7:0] pec_byte,
    output logic [7:0] pec_value,
    // Raw measurements
    input wire logic sample_valid,
    input wire logic [23:0] raw_voltage,
    input wire logic [23:0] raw_current_value,
    input wire logic signed [23:0] raw_active_power,
    // Corrected results
    output logic [23:0] rms_voltage,
    output logic [23:0] rms_current,
    output logic signed [23:0] active_power,
    output logic [23:0] apparent_power,
    output logic [23:0] reactive_power,
    output logic signed [23:0] average_power_result,
    output logic result_valid,
    // Operating controls
    output logic current_input_disable,
    output logic error_code_enable,
    output logic average_power_run,
    output logic aux_pulse_width_select,
    output logic gain_switching_disable,
    output logic current_amp_gain_select,
    output logic alternating_mode_select
);

    // --------------------
    // Helpers
    // --------------------
    function automatic logic signed [47:0] gain_apply(
        input logic signed [47:0] x, input logic signed [31:0] c);
        logic signed [79:0] m;
        m = 80'(x) * 80'(c);
        return x + $signed(m[63:16]);
    endfunction

    function automatic logic [23:0] sat_u24(input logic signed [47:0] x);
        return x < 0 ? 24'h00_0000 :
            (x > 48'sh0000_00FF_FFFF ? 24'hFF_FFFF : x[23:0]);
    endfunction

    function automatic logic [23:0] sat_s24(input logic signed [47:0] x);
        return x < -48'sh0000_0080_0000 ? 24'h80_0000 :
            (x > 48'sh0000_007F_FFFF ? 24'h7F_FFFF : x[23:0]);
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] c,
        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++)
            r = r[7] ? {r[6:0], 1'b0} ^ `PMCC_CRC_POLY : {r[6:0], 1'b0};
        return r;
    endfunction

    // --------------------
    // Reset release
    // --------------------
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // --------------------
    // Configuration and coefficients
    // --------------------
    logic [15:0] cfg_q;
    logic signed [15:0] vg_q, ig_q, pg_q, poff_q, rc_q, cvg_q, ioff_q, iov_q;
    wire wr_cfg = reg_wr && reg_addr == `PMCC_CMD_CFG;
    // Bit 5 is hardware owned; bits 10-11 are kept clear
    wire [15:0] cfg_wr_val = {reg_wdata[15:10] & 6'h3C, reg_wdata[9:6],
        cfg_q[`PMCC_CFG_DONE], reg_wdata[4:0]};
    wire run_set = wr_cfg && reg_wdata[`PMCC_CFG_RUN]
        && !cfg_q[`PMCC_CFG_RUN];
    wire run_clr = wr_cfg && !reg_wdata[`PMCC_CFG_RUN]
        && cfg_q[`PMCC_CFG_RUN];
    logic avg_fin;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_q <= `PMCC_CFG_RESET;
        else
        begin
            if (wr_cfg)
                cfg_q <= cfg_wr_val;
            if (run_set)
                cfg_q[`PMCC_CFG_DONE] <= 1'b0;
            else if (avg_fin)
                cfg_q[`PMCC_CFG_DONE] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vg_q <= 16'h0000;
            ig_q <= 16'h0000;
            pg_q <= 16'h0000;
            poff_q <= 16'h0000;
            rc_q <= 16'h0000;
            cvg_q <= 16'h0000;
            ioff_q <= 16'h0000;
            iov_q <= 16'h0000;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `PMCC_CMD_VGAIN) vg_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_IGAIN) ig_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_PGAIN) pg_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_POFFS) poff_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_RCP) rc_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_CVG) cvg_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_IOFFS) ioff_q <= reg_wdata;
            if (reg_addr == `PMCC_CMD_IOV) iov_q <= reg_wdata;
        end
    end

    assign current_input_disable = cfg_q[`PMCC_CFG_NOCUR];
    assign error_code_enable = cfg_q[`PMCC_CFG_PEC];
    assign average_power_run = cfg_q[`PMCC_CFG_RUN];
    assign aux_pulse_width_select = cfg_q[6];
    assign gain_switching_disable = cfg_q[7];
    assign current_amp_gain_select = cfg_q[8];
    assign alternating_mode_select = cfg_q[9];

    // --------------------
    // Packet-error code
    // --------------------
    logic [7:0] pec_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pec_q <= 8'h00;
        else if (pec_clear)
            pec_q <= 8'h00;
        else if (pec_byte_valid && cfg_q[`PMCC_CFG_PEC])
            pec_q <= crc8(pec_q, pec_byte);
    end

    assign pec_value = pec_q;

    // --------------------
    // Correction datapath
    // --------------------
    pmcc_state_t state_q;
    logic [23:0] volt_q, cur_q, s_q, q_q, iraw_q;
    logic signed [23:0] p_q, praw_q, avg_q;
    logic valid_q, p_new_q;
    logic idiv_done, sq_done;
    logic [47:0] idiv_quo;
    logic [23:0] sq_root;

    wire take = state_q == st_idle && sample_valid;
    wire take_i = take && !cfg_q[`PMCC_CFG_NOCUR];
    wire [23:0] volt_c = sat_u24(gain_apply(48'(raw_voltage),
        32'(vg_q)));
    wire signed [47:0] vx = $signed({24'h00_0000, volt_q});
    wire signed [63:0] ov_m = 64'(iov_q) * 64'(vx);
    wire signed [63:0] gv_m = 64'(cvg_q) * 64'(vx);
    wire signed [31:0] ig_eff = 32'(ig_q) + gv_m[47:16];
    wire [15:0] rc_mag = rc_q[15] ? 16'(-rc_q) : rc_q;
    // Reciprocal term is zero for a zero raw current rather than saturating
    wire signed [47:0] rc_t = iraw_q == 24'h00_0000 ? 48'sh0 :
        (rc_q[15] ? -$signed({1'b0, idiv_quo[46:0]})
        : $signed({1'b0, idiv_quo[46:0]}));
    wire signed [47:0] cur_sum = 48'(ioff_q) + ov_m[63:16]
        + gain_apply($signed({24'h00_0000, iraw_q}), ig_eff) + rc_t;
    wire signed [47:0] p_c = gain_apply(gain_apply(gain_apply(
        48'(praw_q) + 48'(poff_q), 32'(vg_q)), 32'(ig_q)),
        32'(pg_q));
    wire [47:0] s_m = volt_q * cur_q;
    wire [23:0] s_c = s_m[47:24];
    wire [23:0] p_mag = p_q[23] ? 24'(-p_q) : p_q;
    wire [47:0] s_sq = s_c * s_c;
    wire [47:0] p_sq = p_mag * p_mag;
    wire [47:0] q_rad = s_sq > p_sq ? s_sq - p_sq : 48'h0000_0000_0000;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= st_idle;
            volt_q <= 24'h00_0000;
            cur_q <= 24'h00_0000;
            s_q <= 24'h00_0000;
            q_q <= 24'h00_0000;
            iraw_q <= 24'h00_0000;
            p_q <= 24'h00_0000;
            praw_q <= 24'h00_0000;
            valid_q <= 1'b0;
            p_new_q <= 1'b0;
        end
        else
        begin
            valid_q <= 1'b0;
            p_new_q <= 1'b0;
            unique case (state_q)
                st_idle:
                    if (take)
                    begin
                        volt_q <= volt_c;
                        // Current path frozen while disabled
                        valid_q <= !take_i;
                        if (take_i)
                        begin
                            iraw_q <= raw_current_value;
                            praw_q <= raw_active_power;
                            state_q <= st_div;
                        end
                    end
                st_div:
                    if (idiv_done)
                    begin
                        cur_q <= sat_u24(cur_sum);
                        p_q <= sat_s24(p_c);
                        p_new_q <= 1'b1;
                        state_q <= st_app;
                    end
                st_app:
                begin
                    s_q <= s_c;
                    state_q <= st_sqrt;
                end
                st_sqrt:
                    if (sq_done)
                    begin
                        q_q <= sq_root;
                        valid_q <= 1'b1;
                        state_q <= st_idle;
                    end
            endcase
        end
    end

    // Reciprocal term; divisor is the held raw current, not the live pin
    pmcc_div u_idiv (
        .clk(sys_clk),
        .rst_n(rst_n),
        .start(take_i),
        .dividend({8'h00, rc_mag, 24'h00_0000}),
        .divisor(iraw_q),
        .done(idiv_done),
        .quotient(idiv_quo)
    );

    pmcc_sqrt u_sqrt (
        .clk(sys_clk),
        .rst_n(rst_n),
        .start(state_q == st_app),
        .radicand(q_rad),
        .done(sq_done),
        .root(sq_root)
    );

    // --------------------
    // Average power
    // --------------------
    logic signed [47:0] sum_q;
    logic [23:0] cnt_q;
    logic avg_neg_q;
    logic adiv_done;
    logic [47:0] adiv_quo;
    wire adiv_start = run_clr && cnt_q != 24'h00_0000;
    wire [47:0] sum_mag = sum_q < 0 ? 48'(-sum_q) : sum_q;

    assign avg_fin = adiv_done || (run_clr && cnt_q == 24'h00_0000);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sum_q <= 48'sh0;
            cnt_q <= 24'h00_0000;
            avg_neg_q <= 1'b0;
            avg_q <= 24'h00_0000;
        end
        else
        begin
            if (run_set)
            begin
                sum_q <= 48'sh0;
                cnt_q <= 24'h00_0000;
            end
            else if (cfg_q[`PMCC_CFG_RUN] && p_new_q)
            begin
                sum_q <= sum_q + 48'(p_q);
                cnt_q <= cnt_q + 24'h00_0001;
            end
            if (adiv_start)
                avg_neg_q <= sum_q < 0;
            if (run_clr && cnt_q == 24'h00_0000)
                avg_q <= 24'h00_0000;
            else if (adiv_done)
                avg_q <= avg_neg_q ? 24'(-adiv_quo[23:0])
                    : adiv_quo[23:0];
        end
    end

    pmcc_div u_adiv (
        .clk(sys_clk),
        .rst_n(rst_n),
        .start(adiv_start),
        .dividend(sum_mag),
        .divisor(cnt_q),
        .done(adiv_done),
        .quotient(adiv_quo)
    );

    // --------------------
    // Read-back
    // --------------------
    logic [23:0] rdata_q;
    wire [23:0] rd_mux =
        reg_addr == `PMCC_CMD_P ? p_q :
        reg_addr == `PMCC_CMD_Q ? q_q :
        reg_addr == `PMCC_CMD_S ? s_q :
        reg_addr == `PMCC_CMD_AVG ? avg_q :
        reg_addr == `PMCC_CMD_VOLT ? volt_q :
        reg_addr == `PMCC_CMD_CURR ? cur_q :
        reg_addr == `PMCC_CMD_CFG ? {8'h00, cfg_q} :
        reg_addr == `PMCC_CMD_VGAIN ? {8'h00, vg_q} :
        reg_addr == `PMCC_CMD_IGAIN ? {8'h00, ig_q} :
        reg_addr == `PMCC_CMD_PGAIN ? {8'h00, pg_q} :
        reg_addr == `PMCC_CMD_POFFS ? {8'h00, poff_q} :
        reg_addr == `PMCC_CMD_RCP ? {8'h00, rc_q} :
        reg_addr == `PMCC_CMD_CVG ? {8'h00, cvg_q} :
        reg_addr == `PMCC_CMD_IOFFS ? {8'h00, ioff_q} :
        reg_addr == `PMCC_CMD_IOV ? {8'h00, iov_q} : 24'h00_0000;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 24'h00_0000;
        else if (reg_rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata = rdata_q;
    assign rms_voltage = volt_q;
    assign rms_current = cur_q;
    assign active_power = p_q;
    assign apparent_power = s_q;
    assign reactive_power = q_q;
    assign average_power_result = avg_q;
    assign result_valid = valid_q;

endmodule // pmcc_top

// File: dv/pmcc_top_assertions.sv
`timescale 1ns/1ps
`include "pmcc_params.svh"

// --------------------
// Port checker
// --------------------
module pmcc_top_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register and error-code ports
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic pec_clear,
    input wire logic pec_byte_valid,
    input wire logic [7:0] pec_value,
    // Sample path
    input wire logic sample_valid,
    input wire logic [23:0] rms_voltage,
    input wire logic [23:0] rms_current,
    input wire logic [23:0] apparent_power,
    input wire logic result_valid,
    // Controls
    input wire logic current_input_disable,
    input wire logic error_code_enable,
    input wire logic average_power_run,
    input wire logic aux_pulse_width_select,
    input wire logic gain_switching_disable,
    input wire logic current_amp_gain_select,
    input wire logic alternating_mode_select
);
    wire [47:0] s_prod = 48'(rms_voltage) * 48'(rms_current);
    wire [3:0] mode_q = {alternating_mode_select, current_amp_gain_select,
        gain_switching_disable, aux_pulse_width_select};

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence cfg_wr;
        reg_wr && reg_addr == `PMCC_CMD_CFG;
    endsequence

    sequence off_sample;
        sample_valid && current_input_disable;
    endsequence

    AST_NOCUR_WR: assert property (cfg_wr |=> current_input_disable == $past(reg_wdata[0]))
        else $error("disable bit wrong");
    AST_PEC_WR: assert property (cfg_wr |=> error_code_enable == $past(reg_wdata[3]))
        else $error("crc enable wrong");
    AST_RUN_WR: assert property (cfg_wr |=> average_power_run == $past(reg_wdata[4]))
        else $error("run bit wrong");
    AST_MODE_WR: assert property (cfg_wr |=> mode_q == $past(reg_wdata[9:6]))
        else $error("mode bits wrong");
    AST_CTL_HOLD: assert property (!reg_wr |=> $stable(mode_q) && $stable(current_input_disable))
        else $error("control moved");
    AST_OFF_VALID: assert property (off_sample |-> ##[1:2] result_valid)
        else $error("no result");
    AST_OFF_HOLD: assert property (off_sample |=> $stable(rms_current) [*2])
        else $error("current moved");
    AST_APP_PROD: assert property (result_valid && !current_input_disable |-> apparent_power == s_prod[47:24])
        else $error("apparent wrong");
    AST_PEC_CLR: assert property (pec_clear && !pec_byte_valid |=> pec_value == 8'h00)
        else $error("crc not cleared");
    AST_PEC_OFF: assert property (pec_byte_valid && !pec_clear && !error_code_enable |=> $stable(pec_value))
        else $error("crc folded");
endmodule // pmcc_top_assertions

bind pmcc_top pmcc_top_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .pec_clear(pec_clear), .pec_byte_valid(pec_byte_valid),
    .pec_value(pec_value), .sample_valid(sample_valid),
    .rms_voltage(rms_voltage), .rms_current(rms_current),
    .apparent_power(apparent_power), .result_valid(result_valid),
    .current_input_disable(current_input_disable),
    .error_code_enable(error_code_enable),
    .average_power_run(average_power_run),
    .aux_pulse_width_select(aux_pulse_width_select),
    .gain_switching_disable(gain_switching_disable),
    .current_amp_gain_select(current_amp_gain_select),
    .alternating_mode_select(alternating_mode_select));

// File: dv/pmcc_master.sv
`timescale 1ns/1ps
`include "pmcc_params.svh"

// --------------------
// Bus master model
// --------------------
module pmcc_master (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [23:0] reg_rdata
);
    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end

    // Released lines show inverted values
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = (a == `PMCC_CMD_CFG) ? ((d | 16'h0002) & 16'hF3FB) : d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask

    task rd(input logic [7:0] a, output logic [23:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // pmcc_master

// File: dv/tb_pmcc_top.sv
`timescale 1ns/1ps
`include "pmcc_params.svh"

module tb_pmcc_top;
    logic sys_clk, arst_n, reg_wr, reg_rd, pec_clear, pec_byte_valid;
    logic sample_valid, result_valid;
    logic [7:0] reg_addr, pec_byte, pec_value;
    logic [15:0] reg_wdata;
    logic [23:0] reg_rdata, raw_voltage, raw_current_value, raw_active_power;
    logic [23:0] rms_voltage, rms_current, active_power, apparent_power;
    logic [23:0] reactive_power, average_power_result, rd;
    logic [6:0] ctl;
    int err_total, compares, cyc, n;
    int bits[6] = '{0, 3, 6, 7, 8, 9};
    int pos[6] = '{0, 1, 3, 4, 5, 6};

    pmcc_master mst (.clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    pmcc_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pec_clear(pec_clear),
        .pec_byte_valid(pec_byte_valid), .pec_byte(pec_byte),
        .pec_value(pec_value), .sample_valid(sample_valid),
        .raw_voltage(raw_voltage), .raw_current_value(raw_current_value),
        .raw_active_power(raw_active_power), .rms_voltage(rms_voltage),
        .rms_current(rms_current), .active_power(active_power),
        .apparent_power(apparent_power), .reactive_power(reactive_power),
        .average_power_result(average_power_result),
        .result_valid(result_valid), .current_input_disable(ctl[0]),
        .error_code_enable(ctl[1]), .average_power_run(ctl[2]),
        .aux_pulse_width_select(ctl[3]), .gain_switching_disable(ctl[4]),
        .current_amp_gain_select(ctl[5]), .alternating_mode_select(ctl[6]));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task finish_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test();
        end
    end

    task smp(input logic [23:0] v, input logic [23:0] i, input logic [23:0] p);
        @(negedge sys_clk);
        sample_valid = 1'b1;
        raw_voltage = v;
        raw_current_value = i;
        raw_active_power = p;
        @(negedge sys_clk);
        sample_valid = 1'b0;
        raw_voltage = ~v;
        n = 0;
        while (result_valid !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(24'(n < 200), 24'h00_0001);
    endtask

    task pec(input logic clr, input logic [7:0] b, input logic [7:0] exp);
        @(negedge sys_clk);
        pec_clear = clr;
        pec_byte_valid = !clr;
        pec_byte = b;
        @(negedge sys_clk);
        pec_clear = 1'b0;
        pec_byte_valid = 1'b0;
        pec_byte = ~b;
        chk(24'(pec_value), 24'(exp));
    endtask

    initial
    begin
        {arst_n, pec_clear, pec_byte_valid, pec_byte, sample_valid} = '0;
        {raw_voltage, raw_current_value, raw_active_power} = '0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        mst.rd(`PMCC_CMD_CFG, rd);
        chk(rd, 24'h00_F122);
        chk(24'(ctl), 24'h00_0020);
        mst.rd(`PMCC_CMD_VGAIN, rd);
        chk(rd, 24'h00_0000);
        mst.rd(8'h01, rd);
        chk(rd, 24'h00_0000);
        $display("test reset done");
        // Writes clear the indicator
        for (int k = 0; k < 6; k++)
        begin
            mst.wr(`PMCC_CMD_CFG, 16'h0001 << bits[k]);
            chk(24'(ctl), 24'h00_0001 << pos[k]);
            mst.rd(`PMCC_CMD_CFG, rd);
            chk(rd, 24'h00_0022 | (24'h00_0001 << bits[k]));
        end
        $display("test config bits done");
        mst.wr(`PMCC_CMD_CFG, 16'h0110);
        mst.rd(`PMCC_CMD_CFG, rd);
        chk(rd, 24'h00_0112);
        smp(24'h14_0000, 24'h10_0000, 24'h01_0000);
        chk(rms_voltage, 24'h14_0000);
        chk(rms_current, 24'h10_0000);
        chk(active_power, 24'h01_0000);
        chk(apparent_power, 24'h01_4000);
        chk(reactive_power, 24'h00_C000);
        smp(24'h14_0000, 24'h10_0000, 24'h00_8000);
        mst.wr(`PMCC_CMD_CFG, 16'h0100);
        mst.rd(`PMCC_CMD_CFG, rd);
        chk(rd, 24'h00_0102);
        n = 0;
        while (rd[5] !== 1'b1 && n < 100)
        begin
            mst.rd(`PMCC_CMD_CFG, rd);
            n++;
        end
        chk(rd, 24'h00_0122);
        chk(average_power_result, 24'h00_C000);
        $display("test average done");
        mst.wr(`PMCC_CMD_VGAIN, 16'h4000);
        mst.wr(`PMCC_CMD_IGAIN, 16'h8000);
        smp(24'h14_0000, 24'h10_0000, 24'h01_0000);
        chk(rms_voltage, 24'h19_0000);
        chk(rms_current, 24'h08_0000);
        chk(active_power, 24'h00_A000);
        chk(apparent_power, 24'h00_C800);
        mst.wr(`PMCC_CMD_CFG, 16'h0101);
        smp(24'h0A_0000, 24'h03_0000, 24'h00_1000);
        chk(rms_voltage, 24'h0C_8000);
        chk(rms_current, 24'h08_0000);
        $display("test datapath done");
        mst.wr(`PMCC_CMD_CFG, 16'h0100);
        pec(1'b1, 8'h00, 8'h00);
        pec(1'b0, 8'h01, 8'h00);
        mst.wr(`PMCC_CMD_CFG, 16'h0108);
        pec(1'b1, 8'h00, 8'h00);
        pec(1'b0, 8'h01, 8'h07);
        pec(1'b0, 8'h01, 8'h12);
        $display("test error code done");
        finish_test();
    end
endmodule // tb_pmcc_top
